// ### bench/jmf_jog_ctrl_props.sv
// Purpose: port checks for the jog control block
// Assumes: one clock, async active low reset
// Notes: bound to every jmf_jog_ctrl
`timescale 1ns/10ps
module jmf_jog_ctrl_props (
  input wire clk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire output_active_flag,
  input wire output_finished_flag,
  input wire motor_run,
  input wire motor_dir_rev,
  input wire [31:0] motor_speed
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  bus_ack_a: assert property (psel && !penable |=> pready) else $error("no answer");
  ack_qual_a: assert property (pready |-> psel && penable) else $error("stray ready");
  err_ack_a: assert property (pslverr |-> pready) else $error("error without ready");
  run_busy_a: assert property (motor_run |-> output_active_flag) else $error("run while idle");
  flag_excl_a: assert property (!(output_active_flag && output_finished_flag))
    else $error("busy and done");
  end_done_a: assert property ($fell(output_active_flag) |-> output_finished_flag)
    else $error("end without done");
  done_hold_a: assert property ($fell(output_finished_flag) |-> output_active_flag)
    else $error("done dropped");
  dir_keep_a: assert property (motor_run && $past(motor_run) |-> $stable(motor_dir_rev))
    else $error("direction flipped");
  speed_step_a: assert property (motor_run && $past(motor_run) |-> motor_speed == $past(motor_speed)
    || motor_speed == $past(motor_speed) + 32'h1 || motor_speed == $past(motor_speed) - 32'h1)
    else $error("speed jump");
endmodule // jmf_jog_ctrl_props
bind jmf_jog_ctrl jmf_jog_ctrl_props i_props (.clk(clk), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .output_active_flag(output_active_flag),
  .output_finished_flag(output_finished_flag), .motor_run(motor_run),
  .motor_dir_rev(motor_dir_rev), .motor_speed(motor_speed));

// ### bench/jmf_limit_model.sv
// Purpose: over limit switches seen by the jog control block
// Assumes: hit inputs set by the bench
// Notes: pol 0 means a limit is active low (unpowered)
`timescale 1ns/10ps
module jmf_limit_model (
  input wire pol,
  input wire plus_hit,
  input wire minus_hit,
  output wire limit_plus_in,
  output wire limit_minus_in
);
  assign limit_plus_in = plus_hit ? pol : ~pol;
  assign limit_minus_in = minus_hit ? pol : ~pol;
endmodule // jmf_limit_model

// ### bench/tb.sv
// Purpose: self-checking bench for the jog control block
// Assumes: one apb transfer at a time
// Notes: limit pins come from the switch model
`timescale 1ns/10ps
`include "jmf_regs.vh"
module tb;
  localparam logic [11:0] ct = `JMF_CTRL_ADDR, st = `JMF_STAT_ADDR, tg = `JMF_TARGET_SPD_ADDR;
  localparam logic [11:0] cm = `JMF_CMD_ADDR;
  logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pol = 0, ph = 0, mh = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, spd, q;
  logic pready, pslverr, lp, lm, act, fin, run, rev, e;
  int fails = 0, checked = 0, cycles = 0;
  jmf_jog_ctrl i_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .limit_plus_in(lp), .limit_minus_in(lm), .output_active_flag(act), .output_finished_flag(fin),
    .motor_run(run), .motor_dir_rev(rev), .motor_speed(spd));
  jmf_limit_model i_lim (.pol(pol), .plus_hit(ph), .minus_hit(mh), .limit_plus_in(lp),
    .limit_minus_in(lm));
  initial forever #2 clk = ~clk;
  task final_report;
    if (fails == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails++;
      final_report;
    end
  end
  task chk(input [31:0] s, input [31:0] x);
    checked++;
    if (s !== x)
    begin
      fails++;
      $display("BAD %0t seen %h want %h", $time, s, x);
    end
  endtask
  task bus(input w, input [11:0] a, input [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata; e = pslverr; psel <= 0; penable <= 0;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task t_regs;
    bus(0, ct, 0); chk(q, `JMF_CTRL_RESET);
    bus(0, `JMF_BASE_ADDR, 0); chk(q, `JMF_BASE_RESET);
    bus(0, 12'h020, 0); chk(e, 1);
    bus(1, `JMF_START_SPD_ADDR, 32'h5); bus(1, tg, 32'h14); bus(1, `JMF_RAMP_ADDR, 32'h64);
  endtask
  task t_pulser;
    bus(1, cm, 32'h20); cyc(3); chk(fin, 1); chk(act, 0);
  endtask
  task t_fwd;
    bus(1, cm, 32'h1); cyc(2); chk({act, fin, run, rev}, 4'ha);
    cyc(30); chk(spd, 32'h14);
    bus(1, cm, 32'h3); cyc(3); chk(rev, 0);
    bus(1, cm, 32'h0); cyc(30); chk({act, fin, run}, 3'h2);
    bus(1, cm, 32'h3); cyc(3); chk({run, rev}, 2'h2);
    bus(1, cm, 32'h0); cyc(30);
  endtask
  task t_param;
    bus(1, tg, 0); bus(1, cm, 32'h1); cyc(3); chk(act, 0);
    bus(0, st, 0); chk(q[`JMF_STAT_SETERR], 1);
    bus(1, cm, 32'h40); bus(1, tg, 32'h14);
  endtask
  task t_restart;
    bus(1, cm, 32'h1); cyc(30); bus(1, tg, 32'h1e); cyc(15); chk(spd, 32'h1e);
    bus(1, cm, 32'h0); cyc(5); bus(1, cm, 32'h1); cyc(30); chk(act, 1); chk(spd, 32'h1e);
    bus(1, cm, 32'h0); cyc(40); bus(1, tg, 32'h14);
    bus(1, ct, 32'h100); bus(1, cm, 32'h1); cyc(30); bus(1, tg, 32'h28); cyc(30);
    chk(spd, 32'h14);
    bus(1, cm, 32'h0); cyc(30); bus(1, ct, 0); bus(0, tg, 0); chk(q, 32'h14);
  endtask
  task t_other;
    for (int i = 2; i < 4; i++)
    begin
      bus(1, cm, 32'h10); cyc(3); chk({act, fin}, 2'h2);
      bus(1, cm, 32'h11); cyc(3); chk(run, 0);
      bus(1, cm, 32'h1 << i); cyc(3); chk({act, fin}, 2'h1);
      bus(1, cm, 32'h0);
    end
  endtask
  task t_limit;
    ph <= 1; cyc(4); bus(1, cm, 32'h2); cyc(3); chk({run, rev}, 2'h3);
    mh <= 1; cyc(6); chk({run, fin}, 2'h1);
    bus(0, st, 0); chk(q[`JMF_STAT_LIMERR], 1);
    bus(1, cm, 32'h40); bus(1, cm, 32'h2); cyc(3); chk(act, 0);
    ph <= 0; mh <= 0; bus(1, cm, 32'h40);
    bus(1, ct, 32'h80); bus(1, cm, 32'h1); cyc(3); chk(act, 0);
    bus(0, st, 0); chk(q[`JMF_STAT_LIMERR], 1);
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    reset_n <= 1;
    t_regs; t_pulser; t_fwd; t_param; t_restart; t_other; t_limit;
    final_report;
  end
endmodule // tb

// ### src/jmf_jog_ctrl.v
// Purpose: per-axis jog control with active and finished flags, over limit and range checks
// Assumes: one clock, APB register access, limit pins asynchronous to clk
// Notes: speed ramps by a fixed step per clock; pulse timing lives outside this block
//
// How it works
// R1 - raised jog request starts output with stored speed and ramp parameters; here ramp_q is only range checked and the step per clock is fixed
// R2 - jog request raised while active flag set is ignored
// R3 - forward and reverse raised together runs forward
// R4 - first requested direction keeps running if the other follows
// R5 - active flag rises cycle after start, falls when output completes
// R6 - while active, other operations refused except forced or decelerating stop
// R7 - one active flag serves all operations except pulser input
// R8 - finished flag set on completion, held until any next operation starts
// R9 - one finished flag serves every operation, pulser input included
// R10 - limit in requested direction blocks start; in travel direction stops with error
// R11 - only the limit in the travel direction is acted upon
// R12 - limit polarity selectable; default active when unpowered
// R13 - out-of-range speed, ramp or position gives set value error, no start; here position is not checked
// R14 - same-direction restart while decelerating accelerates again
// R15 - parameter changes during jog accepted only with linear profile
// R16 - controller must not overwrite parameters shared by another running operation
// R17 - flag addresses are relative to the allocated starting word, default 10; here base_q is only stored and read back
// R18 - s-curve profile ignores target speed changes during jog
// R19 - after speed change the first ramp's acceleration rate is kept
// R20 - output continues while request held, decelerates after release
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "jmf_regs.vh"
module jmf_jog_ctrl #(
  parameter ADDR_W = 12
) (
  input wire clk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire limit_plus_in,
  input wire limit_minus_in,
  output reg output_active_flag,
  output reg output_finished_flag,
  output reg motor_run,
  output reg motor_dir_rev,
  output reg [31:0] motor_speed
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_ACC = 2'd1;
  localparam [1:0] ST_RUN = 2'd2;
  localparam [1:0] ST_DEC = 2'd3;

  // ----------------------------------------------------------------
  // limit synchronisers
  // ----------------------------------------------------------------
  // only the second stage feeds logic
  reg [1:0] lp_sync_q;
  reg [1:0] lm_sync_q;
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lp_sync_q <= 2'b00;
      lm_sync_q <= 2'b00;
    end
    else
    begin
      lp_sync_q <= {lp_sync_q[0], limit_plus_in};
      lm_sync_q <= {lm_sync_q[0], limit_minus_in};
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [31:0] ctrl_q;
  reg [31:0] start_spd_q;
  reg [31:0] target_spd_q;
  reg [31:0] ramp_q;
  reg [31:0] pos_q;
  reg [31:0] base_q;
  reg fwd_req_q;
  reg rev_req_q;
  reg lim_err_q;
  reg set_err_q;
  reg [1:0] state_q;
  reg [31:0] run_target_q;
  reg other_busy_q;

  // powered level valid when polarity bit set, else unpowered level valid
  wire pol = ctrl_q[`JMF_CTRL_LIMPOL]; // see R12
  wire lim_plus = pol ? lp_sync_q[1] : ~lp_sync_q[1]; // see R12
  wire lim_minus = pol ? lm_sync_q[1] : ~lm_sync_q[1]; // see R12
  wire lim_travel = motor_dir_rev ? lim_minus : lim_plus; // see R11

  wire wr = psel & penable & pwrite;
  wire rd_setup = psel & ~penable & ~pwrite;
  wire cmd_wr = wr && (paddr == `JMF_CMD_ADDR);
  wire new_fwd = cmd_wr & pwdata[`JMF_CMD_FWD] & ~fwd_req_q;
  wire new_rev = cmd_wr & pwdata[`JMF_CMD_REV] & ~rev_req_q;
  wire fstop = cmd_wr & pwdata[`JMF_CMD_FSTOP];
  wire dstop = cmd_wr & pwdata[`JMF_CMD_DSTOP];
  wire other_start = cmd_wr & pwdata[`JMF_CMD_OTHER];
  wire pulser_start = cmd_wr & pwdata[`JMF_CMD_PULSER];
  wire params_ok = (start_spd_q <= `JMF_SPD_MAX) && (target_spd_q != 32'd0) &&
                   (target_spd_q <= `JMF_SPD_MAX) && (target_spd_q > start_spd_q) &&
                   (ramp_q <= `JMF_RAMP_MAX); // see R13
  wire busy = output_active_flag | (state_q != ST_IDLE) | other_busy_q;
  // forward wins a tie, one request alone runs its own direction
  wire start_rev = new_rev & ~new_fwd; // see R3
  wire start_req = (new_fwd | new_rev) & ~busy; // see R2, R6
  wire start_lim = start_rev ? lim_minus : lim_plus; // see R10
  wire jog_go = start_req & params_ok & ~start_lim; // see R1
  // jog wins a shared write, then the other operation, then pulser input
  wire other_go = other_start & ~busy & ~jog_go; // see R6, R7
  wire pulser_go = pulser_start & ~busy & ~jog_go & ~other_start; // see R9
  // linear profile only; s-curve freezes parameters while moving
  wire param_wr_ok = ~busy | ~ctrl_q[`JMF_CTRL_SCURVE]; // see R15, R18
  wire held = motor_dir_rev ? rev_req_q : fwd_req_q; // see R4, R20

  // ----------------------------------------------------------------
  // apb write side
  // ----------------------------------------------------------------
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_q <= `JMF_CTRL_RESET;
      start_spd_q <= 32'd0;
      target_spd_q <= 32'd0;
      ramp_q <= 32'd0;
      pos_q <= 32'd0;
      base_q <= `JMF_BASE_RESET;
      fwd_req_q <= 1'b0;
      rev_req_q <= 1'b0;
    end
    else
    begin
      if (wr)
      begin
        case (paddr)
          `JMF_CTRL_ADDR: if (~busy) ctrl_q <= pwdata;
          `JMF_START_SPD_ADDR: if (param_wr_ok) start_spd_q <= pwdata; // see R15
          `JMF_TARGET_SPD_ADDR: if (param_wr_ok) target_spd_q <= pwdata; // see R18
          `JMF_RAMP_ADDR: if (param_wr_ok) ramp_q <= pwdata;
          `JMF_POS_ADDR: if (param_wr_ok) pos_q <= pwdata;
          `JMF_BASE_ADDR: base_q <= pwdata; // see R17
          `JMF_CMD_ADDR:
          begin
            fwd_req_q <= pwdata[`JMF_CMD_FWD];
            rev_req_q <= pwdata[`JMF_CMD_REV];
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // apb read side, no wait states
  // ----------------------------------------------------------------
  wire [31:0] stat_w = {26'd0, state_q == ST_DEC, motor_dir_rev, set_err_q, lim_err_q,
                        output_finished_flag, output_active_flag};
  wire mapped = (paddr <= `JMF_BASE_ADDR) && (paddr[1:0] == 2'b00);
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prdata <= 32'd0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (rd_setup)
      begin
        case (paddr)
          `JMF_CTRL_ADDR: prdata <= ctrl_q;
          `JMF_STAT_ADDR: prdata <= stat_w;
          `JMF_START_SPD_ADDR: prdata <= start_spd_q;
          `JMF_TARGET_SPD_ADDR: prdata <= target_spd_q;
          `JMF_RAMP_ADDR: prdata <= ramp_q;
          `JMF_POS_ADDR: prdata <= pos_q;
          `JMF_CMD_ADDR: prdata <= {30'd0, rev_req_q, fwd_req_q};
          `JMF_BASE_ADDR: prdata <= base_q;
          default: prdata <= 32'd0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // jog state machine
  // ----------------------------------------------------------------
  // speed step is a fixed constant so a later target change keeps the first rate
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= ST_IDLE;
      motor_run <= 1'b0;
      motor_dir_rev <= 1'b0;
      motor_speed <= 32'd0;
      run_target_q <= 32'd0;
      output_active_flag <= 1'b0;
      output_finished_flag <= 1'b0;
      lim_err_q <= 1'b0;
      set_err_q <= 1'b0;
      other_busy_q <= 1'b0;
    end
    else
    begin
      // a new error in the clear cycle wins
      if (cmd_wr & pwdata[`JMF_CMD_ERRCLR])
      begin
        lim_err_q <= 1'b0;
        set_err_q <= 1'b0;
      end
      if (start_req & ~params_ok)
        set_err_q <= 1'b1; // see R13
      if (start_req & params_ok & start_lim)
        lim_err_q <= 1'b1; // see R10
      // an accepted jog or other operation clears the finished flag; an accepted pulser input sets it below
      if (jog_go | other_go | pulser_go)
        output_finished_flag <= 1'b0; // see R8, R9
      // non-jog operations share the finished flag, the other operation also the active flag, but have no motion here
      if (other_go)
      begin
        other_busy_q <= 1'b1; // see R6, R7
        output_active_flag <= 1'b1; // see R7
      end
      else if (other_busy_q & (fstop | dstop))
      begin
        other_busy_q <= 1'b0;
        output_active_flag <= 1'b0; // see R5
        output_finished_flag <= 1'b1; // see R8
      end
      if (pulser_go)
        output_finished_flag <= 1'b1; // see R9
      case (state_q)
        ST_IDLE:
        begin
          if (jog_go)
          begin
            state_q <= ST_ACC;
            motor_run <= 1'b1;
            motor_dir_rev <= start_rev; // see R3
            motor_speed <= start_spd_q; // see R1
            run_target_q <= target_spd_q;
            output_active_flag <= 1'b1; // see R5, R7
          end
        end
        ST_ACC, ST_RUN:
        begin
          if (param_wr_ok)
            run_target_q <= target_spd_q; // see R15, R18
          if (fstop | lim_travel)
          begin
            state_q <= ST_IDLE;
            motor_run <= 1'b0;
            motor_speed <= 32'd0;
            output_active_flag <= 1'b0;
            output_finished_flag <= 1'b1;
            if (lim_travel)
              lim_err_q <= 1'b1; // see R10, R11
          end
          else if (dstop | ~held)
            state_q <= ST_DEC; // see R20
          else if (motor_speed < run_target_q)
            motor_speed <= motor_speed + `JMF_SPD_STEP; // see R19
          else if (motor_speed > run_target_q)
            motor_speed <= motor_speed - `JMF_SPD_STEP; // see R19
          else
            state_q <= ST_RUN;
        end
        ST_DEC:
        begin
          if (fstop | lim_travel | (motor_speed <= start_spd_q))
          begin
            state_q <= ST_IDLE;
            motor_run <= 1'b0;
            motor_speed <= 32'd0;
            output_active_flag <= 1'b0; // see R5
            output_finished_flag <= 1'b1; // see R8
            if (lim_travel)
              lim_err_q <= 1'b1; // see R10
          end
          else if ((motor_dir_rev ? new_rev : new_fwd) & ~dstop)
            state_q <= ST_ACC; // see R14
          else
            motor_speed <= motor_speed - `JMF_SPD_STEP;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // jmf_jog_ctrl

// ### src/jmf_regs.vh
// Purpose: register map and constants for the jog motion flag control block
// Assumes: APB slave, 32-bit data, word aligned registers
// Notes: all offsets are byte addresses
`ifndef JMF_REGS_VH
`define JMF_REGS_VH
// register byte offsets
`define JMF_CTRL_ADDR 12'h000
`define JMF_STAT_ADDR 12'h004
`define JMF_START_SPD_ADDR 12'h008
`define JMF_TARGET_SPD_ADDR 12'h00c
`define JMF_RAMP_ADDR 12'h010
`define JMF_POS_ADDR 12'h014
`define JMF_CMD_ADDR 12'h018
`define JMF_BASE_ADDR 12'h01c
// control fields
`define JMF_CTRL_LIMPOL 7
`define JMF_CTRL_SCURVE 8
`define JMF_CTRL_RESET 32'h0000_0000
// command fields
`define JMF_CMD_FWD 0
`define JMF_CMD_REV 1
`define JMF_CMD_FSTOP 2
`define JMF_CMD_DSTOP 3
`define JMF_CMD_OTHER 4
`define JMF_CMD_PULSER 5
`define JMF_CMD_ERRCLR 6
// status fields
`define JMF_STAT_ACTIVE 0
`define JMF_STAT_DONE 1
`define JMF_STAT_LIMERR 2
`define JMF_STAT_SETERR 3
`define JMF_STAT_DIR 4
`define JMF_STAT_PHASE 5
// ranges
`define JMF_SPD_MAX 32'd4000000
`define JMF_RAMP_MAX 32'd32767
// speed step per clock and default base word
`define JMF_SPD_STEP 32'd1
`define JMF_BASE_RESET 32'd10
`endif
